// File: design/rrse_core.v
// rrse_core.v: executes rotate-through-carry, subroutine return and power-down.
// assumes insn_valid_i marks one instruction cycle and the file read data
// for insn_i[6:0] is presented combinationally on file_rdata_i.
// wake-up sources, stack depth and watchdog counting live outside this block;
// wake_i only restarts the oscillator once the core sleeps.
`timescale 1ns/1ps
`include "rrse_defs.vh"

// What this block does
// RQ1: left rotate through carry, old carry into bit 0, bit 7 to carry.
// RQ2: destination bit 0 writes accumulator, 1 writes back source register.
// RQ3: register operand is 7-bit address 0..127, destination one bit.
// RQ4: each rotate finishes in one instruction cycle as one word.
// RQ5: right rotate through carry, old carry into bit 7, bit 0 to carry.
// RQ6: power-down clears power-down flag, sets timeout flag, nothing else.
// RQ7: power-down loads watchdog counter with zero and clears its prescaler.
// RQ8: power-down halts the oscillator so execution stops.
// RQ9: return pops stack head into program counter, two cycles, flags untouched.
// RQ10: power-down is single-cycle; flags visible before oscillator halts.
module rrse_core (
   input  wire        core_clk_i,       // instruction clock
   input  wire        sys_rst_i,        // synchronous reset, active high
   input  wire        insn_valid_i,     // instruction present this cycle
   input  wire [13:0] insn_i,           // instruction word
   input  wire [7:0]  file_rdata_i,     // data of addressed file register
   input  wire [12:0] stack_head_i,     // top stack entry
   input  wire        wake_i,           // wake-up request restarts oscillator
   output reg  [6:0]  file_addr_o,      // file register address
   output reg  [7:0]  file_wdata_o,     // write-back data
   output reg         file_we_o,        // write-back strobe, one cycle
   output reg  [7:0]  acc_o,            // accumulator
   output reg         carry_flag_o,     // carry status flag
   output reg         timeout_flag_o,   // time-out status flag
   output reg         power_down_flag_o,// power-down status flag
   output reg  [7:0]  watchdog_counter_o, // watchdog count
   output reg  [7:0]  wdog_presc_o,     // watchdog prescaler
   output reg         wdog_clr_o,       // watchdog clear pulse
   output reg  [12:0] pc_o,             // program counter after pop
   output reg         pc_load_o,        // program counter load pulse
   output reg         stack_pop_o,      // stack pop pulse
   output reg         flush_o,          // discard prefetched instruction
   output reg         osc_run_o,        // oscillator enable
   output reg         busy_o            // second cycle of return in progress
);
   localparam ST_RUN   = 2'h0;
   localparam ST_FLUSH = 2'h1;
   localparam ST_HALT1 = 2'h2;
   localparam ST_SLEEP = 2'h3;

   reg  [1:0] state_reg;
   reg  [1:0] state_next;

   // instruction fields
   wire [5:0] op_hi;
   wire       dest;
   wire [6:0] faddr;
   // opcode decode, qualified by the valid strobe
   wire       is_rotl;
   wire       is_rotr;
   wire       is_rot;
   wire       is_ret;
   wire       is_slp;
   // only the run state executes; the flush slot and sleep drop the word
   wire       in_run;
   wire       do_rot;
   wire       do_ret;
   wire       do_slp;
   wire       do_halt;
   wire       do_wake;
   wire       wr_file;
   wire       wr_acc;
   wire [7:0] rot_res;
   wire       rot_c;

   assign op_hi   = insn_i[`RRSE_OP_HI_MSB:`RRSE_OP_HI_LSB];
   assign dest    = insn_i[`RRSE_DEST_BIT];                          // RQ3
   assign faddr   = insn_i[`RRSE_FADDR_MSB:0];                       // RQ3
   assign is_rotl = insn_valid_i && (op_hi == `RRSE_OP_ROTL);
   assign is_rotr = insn_valid_i && (op_hi == `RRSE_OP_ROTR);
   assign is_rot  = is_rotl || is_rotr;
   assign is_ret  = insn_valid_i && (insn_i == `RRSE_INSN_RETURN);
   assign is_slp  = insn_valid_i && (insn_i == `RRSE_INSN_SLEEP);
   assign in_run  = (state_reg == ST_RUN);
   assign do_rot  = in_run && is_rot;                                // RQ4
   assign do_ret  = in_run && is_ret;                                // RQ9
   assign do_slp  = in_run && is_slp;                                // RQ10
   assign do_halt = (state_reg == ST_HALT1);                         // RQ8
   assign do_wake = (state_reg == ST_SLEEP) && wake_i;
   assign wr_file = do_rot && dest;                                  // RQ2
   assign wr_acc  = do_rot && !dest;                                 // RQ2

   // one shared rotator; direction comes from the decoded opcode
   rrse_rotator i_rrse_rotator (
      .data_i   (file_rdata_i),
      .carry_i  (carry_flag_o),
      .left_i   (is_rotl),                                           // RQ1
      .result_o (rot_res),
      .carry_o  (rot_c)
   );

   // sequencing: run, one flush slot after return, halt then sleep
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (is_ret) begin
               state_next = ST_FLUSH;                                // RQ9
            end else if (is_slp) begin
               state_next = ST_HALT1;                                // RQ10
            end
         end
         ST_FLUSH: begin
            state_next = ST_RUN;                                     // RQ9
         end
         ST_HALT1: begin
            state_next = ST_SLEEP;                                   // RQ8
         end
         ST_SLEEP: begin
            if (wake_i) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // file port: the address follows the instruction every cycle
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         file_addr_o  <= `RRSE_FADDR_RST;
         file_wdata_o <= `RRSE_FWDATA_RST;
         file_we_o    <= `RRSE_PULSE_RST;
      end else begin
         file_addr_o <= faddr;                                       // RQ3
         file_we_o   <= wr_file;                                     // RQ2 RQ4
         if (wr_file) begin
            file_wdata_o <= rot_res;                                 // RQ2
         end
      end
   end

   // accumulator takes the result only when the destination bit is 0
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         acc_o <= `RRSE_ACC_RST;
      end else if (wr_acc) begin
         acc_o <= rot_res;                                           // RQ2
      end
   end

   // carry changes only on a rotate; return and power-down keep it
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         carry_flag_o <= `RRSE_CARRY_RST;
      end else if (do_rot) begin
         carry_flag_o <= rot_c;                                      // RQ1 RQ5
      end
   end

   // status flags: only power-down entry touches them here
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         timeout_flag_o    <= `RRSE_TIMEOUT_RST;
         power_down_flag_o <= `RRSE_PDOWN_RST;
      end else if (do_slp) begin
         timeout_flag_o    <= 1'h1;                                  // RQ6
         power_down_flag_o <= 1'h0;                                  // RQ6
      end
   end

   // watchdog counter and prescaler are cleared on power-down entry
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         watchdog_counter_o <= `RRSE_WDOG_CLEAR;
         wdog_presc_o       <= `RRSE_PRESC_CLEAR;
         wdog_clr_o         <= `RRSE_PULSE_RST;
      end else begin
         wdog_clr_o <= do_slp;                                       // RQ7
         if (do_slp) begin
            watchdog_counter_o <= `RRSE_WDOG_CLEAR;                  // RQ7
            wdog_presc_o       <= `RRSE_PRESC_CLEAR;                 // RQ7
         end
      end
   end

   // return: load the popped entry and mark the prefetched word as dead
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pc_o        <= `RRSE_PC_RST;
         pc_load_o   <= `RRSE_PULSE_RST;
         stack_pop_o <= `RRSE_PULSE_RST;
         flush_o     <= `RRSE_PULSE_RST;
         busy_o      <= `RRSE_PULSE_RST;
      end else begin
         pc_load_o   <= do_ret;                                      // RQ9
         stack_pop_o <= do_ret;                                      // RQ9
         flush_o     <= do_ret;                                      // RQ9
         busy_o      <= do_ret;
         if (do_ret) begin
            pc_o <= stack_head_i;                                    // RQ9
         end
      end
   end

   // oscillator drops one cycle after power-down so the flags settle first
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         osc_run_o <= `RRSE_OSC_RST;
      end else if (do_halt) begin
         osc_run_o <= 1'h0;                                          // RQ8 RQ10
      end else if (do_wake) begin
         osc_run_o <= 1'h1;
      end
   end
endmodule

// File: design/rrse_defs.vh
// rrse_defs.vh: opcode fields, encodings and reset values for the
// rotate / return / sleep execution block.
// assumes a 14-bit instruction word presented one per instruction cycle.
`ifndef RRSE_DEFS_VH
`define RRSE_DEFS_VH
`define RRSE_OP_HI_MSB      13
`define RRSE_OP_HI_LSB      8
`define RRSE_OP_ROTL        6'h0d
`define RRSE_OP_ROTR        6'h0c
`define RRSE_DEST_BIT       7
`define RRSE_FADDR_MSB      6
`define RRSE_INSN_RETURN    14'h0008
`define RRSE_INSN_SLEEP     14'h0063
`define RRSE_WDOG_CLEAR     8'h00
`define RRSE_PRESC_CLEAR    8'h00
`define RRSE_CARRY_RST      1'h0
`define RRSE_ACC_RST        8'h00
`define RRSE_TIMEOUT_RST    1'h1
`define RRSE_PDOWN_RST      1'h1
`define RRSE_PC_RST         13'h0000
`define RRSE_FADDR_RST      7'h00
`define RRSE_FWDATA_RST     8'h00
`define RRSE_PULSE_RST      1'h0
`define RRSE_OSC_RST        1'h1
`endif

// File: design/rrse_rotator.v
// rrse_rotator.v: one-place rotate through carry, either direction.
// assumes purely combinational use by the execution core.
`timescale 1ns/1ps
module rrse_rotator (
   input  wire [7:0] data_i,       // operand from file register
   input  wire       carry_i,      // current carry flag
   input  wire       left_i,       // 1 rotate left, 0 rotate right
   output wire [7:0] result_o,     // rotated value
   output wire       carry_o       // new carry flag
);
   assign result_o = left_i ? {data_i[6:0], carry_i} : {carry_i, data_i[7:1]};
   assign carry_o  = left_i ? data_i[7] : data_i[0];
endmodule

// File: verif/rrse_core_sva.sv
// rrse_core_sva.sv: port-level checks for the rotate/return/sleep core.
// assumes bind to rrse_core; opcodes taken only in run state.
`timescale 1ns/1ps
module rrse_core_sva (
   input wire core_clk_i, sys_rst_i, insn_valid_i, wake_i, file_we_o, carry_flag_o, timeout_flag_o,
   input wire power_down_flag_o, wdog_clr_o, pc_load_o, stack_pop_o, flush_o, osc_run_o,
   input wire [13:0] insn_i,
   input wire [12:0] stack_head_i, pc_o,
   input wire [7:0]  file_rdata_i, file_wdata_o, acc_o, watchdog_counter_o, wdog_presc_o,
   input wire [6:0]  file_addr_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // return blocks the next slot and sleep the slots after it; checks skip two slots after either
   wire rs = insn_valid_i && (insn_i == 14'h0008 || insn_i == 14'h0063);
   sequence s_go; insn_valid_i && osc_run_o && !$past(rs) && !$past(rs, 2); endsequence
   sequence s_slp; s_go ##0 insn_i == 14'h0063; endsequence
   wire [7:0] res = file_we_o ? file_wdata_o : acc_o;
   property p_rotl;
      s_go ##0 insn_i[13:8] == 6'h0d |=> res == {$past(file_rdata_i[6:0]), $past(carry_flag_o)}
         && carry_flag_o == $past(file_rdata_i[7]);
   endproperty
   a_rotl: assert property (p_rotl) else $error("left rotate wrong");
   property p_rotr;
      s_go ##0 insn_i[13:8] == 6'h0c |=> res == {$past(carry_flag_o), $past(file_rdata_i[7:1])}
         && carry_flag_o == $past(file_rdata_i[0]);
   endproperty
   a_rotr: assert property (p_rotr) else $error("right rotate wrong");
   property p_dest; s_go ##0 insn_i[13:9] == 5'h06 |=> file_we_o == $past(insn_i[7]); endproperty
   a_dest: assert property (p_dest) else $error("destination select wrong");
   property p_addr; insn_valid_i |=> file_addr_o == $past(insn_i[6:0]); endproperty
   a_addr: assert property (p_addr) else $error("file address wrong");
   property p_ret;
      s_go ##0 insn_i == 14'h0008 |=> pc_load_o && stack_pop_o && flush_o && pc_o == $past(stack_head_i)
         && $stable(carry_flag_o) ##1 !pc_load_o && !file_we_o;
   endproperty
   a_ret: assert property (p_ret) else $error("return wrong");
   property p_slp; s_slp |=> !power_down_flag_o && timeout_flag_o && $stable(carry_flag_o); endproperty
   a_slp: assert property (p_slp) else $error("sleep flags wrong");
   property p_wdog; s_slp |=> watchdog_counter_o == 8'h00 && wdog_presc_o == 8'h00 && wdog_clr_o; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog not cleared");
   property p_halt; s_slp |=> osc_run_o ##1 !osc_run_o; endproperty
   a_halt: assert property (p_halt) else $error("oscillator not halted");
   property p_hold; !osc_run_o && !wake_i |=> !osc_run_o && !file_we_o; endproperty
   a_hold: assert property (p_hold) else $error("ran while asleep");
endmodule
bind rrse_core rrse_core_sva i_rrse_core_sva (.*);

// File: verif/rrse_core_test.sv
// rrse_core_test.sv: directed tests of rotate, return and sleep.
// assumes inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module rrse_core_test;
   logic clk = 0, rst = 1, v = 0, wake = 0;
   logic [13:0] insn = 0;
   logic [7:0] rd = 0;
   logic [12:0] sh = 0;
   int num_errors = 0, samples_checked = 0;
   wire [6:0] fa;
   wire [7:0] wd, acc, wdc, ps;
   wire [12:0] pc;
   wire we, cf, tf, pf, wc, pl, sp, fl, osc, bz;
   rrse_core i_rrse_core (.core_clk_i(clk), .sys_rst_i(rst), .insn_valid_i(v), .insn_i(insn),
      .file_rdata_i(rd), .stack_head_i(sh), .wake_i(wake), .file_addr_o(fa), .file_wdata_o(wd),
      .file_we_o(we), .acc_o(acc), .carry_flag_o(cf), .timeout_flag_o(tf), .power_down_flag_o(pf),
      .watchdog_counter_o(wdc), .wdog_presc_o(ps), .wdog_clr_o(wc), .pc_o(pc), .pc_load_o(pl),
      .stack_pop_o(sp), .flush_o(fl), .osc_run_o(osc), .busy_o(bz));
   always #2 clk = ~clk;
   task step; @(posedge clk); #1; endtask
   // valid stays up after a transfer; the next call changes the word and the read data
   task exec(input [13:0] i, input [7:0] d); insn = i; rd = d; v = 1; step; endtask
   task test_rotl;
      exec(14'h0dff, 8'he6); `CHK({we, wd, cf, fa}, {1'b1, 8'hcc, 1'b1, 7'h7f})
      exec(14'h0d05, 8'h26); `CHK({we, acc, cf, fa}, {1'b0, 8'h4d, 1'b0, 7'h05})
      $display("test rotl done");
   endtask
   task test_rotr;
      exec(14'h0c00, 8'he7); `CHK({we, acc, cf}, {1'b0, 8'h73, 1'b1})
      exec(14'h0cff, 8'h02); `CHK({we, wd, cf}, {1'b1, 8'h81, 1'b0})
      $display("test rotr done");
   endtask
   task test_ret;
      sh = 13'h1abc;
      exec(14'h0008, 8'h00); `CHK({pc, pl, sp, fl, bz, cf}, {13'h1abc, 4'hf, 1'b0})
      exec(14'h0dff, 8'hff); `CHK({pl, we, cf}, 3'h0)
      $display("test ret done");
   endtask
   task test_sleep;
      exec(14'h0063, 8'h00); `CHK({pf, tf, wdc, ps, wc, osc}, {2'b01, 16'h0000, 2'b11})
      exec(14'h0dff, 8'hff); `CHK(osc, 1'b0)
      step; `CHK({osc, we, cf}, 3'h0)
      wake = 1; step; wake = 0; `CHK(osc, 1'b1)
      exec(14'h0c85, 8'h01); `CHK({we, wd, cf, fa}, {1'b1, 8'h00, 1'b1, 7'h05})
      $display("test sleep done");
   endtask
   task test_reset;
      rst = 1; step; step; rst = 0;
      `CHK({osc, tf, pf, cf, we, pl, wc, acc, pc}, {3'h7, 4'h0, 8'h00, 13'h0000})
      exec(14'h0d80, 8'h81); `CHK({we, wd, cf, fa}, {1'b1, 8'h02, 1'b1, 7'h00})
      $display("test reset done");
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) step;
      rst = 0;
      `CHK({osc, tf, pf}, 3'h7)
      test_rotl; test_rotr; test_ret; test_sleep; test_reset;
      summarize;
   end
   initial begin
      #4000; num_errors++; summarize;
   end
endmodule
